//--- hdl/nfcd_cfg.svh
// Register offsets, field positions, reset values and timing counts of the flash controller front end.
`ifndef NFCD_CFG_SVH
`define NFCD_CFG_SVH
`define NFCD_OFS_CONTROL 4'h0
`define NFCD_OFS_DESCRIPTOR 4'h4
`define NFCD_OFS_STATUS 4'h8
`define NFCD_OFS_OPERATION 4'hC
`define NFCD_BIT_ENABLE 0
`define NFCD_DESC_BYTES 8
`define NFCD_IDX_NAND_PAGE 3'h0
`define NFCD_IDX_CARD_PAGE 3'h1
`define NFCD_IDX_SUB_ONE 3'h2
`define NFCD_IDX_SUB_TWO 3'h3
`define NFCD_IDX_FIRST_HIGH 3'h4
`define NFCD_IDX_FIRST_LOW 3'h5
`define NFCD_IDX_LAST_HIGH 3'h6
`define NFCD_IDX_LAST_LOW 3'h7
`define NFCD_PAGE_MASK 8'hF8
`define NFCD_SUB_ONE_MASK 8'h7F
`define NFCD_SUB_TWO_MASK 8'h03
`define NFCD_RST_PAGE 8'h00
`define NFCD_RST_SUB_ONE 8'h1E
`define NFCD_RST_SUB_TWO 8'h00
`define NFCD_RST_PROT 8'h00
`define NFCD_CYCLE_NS 35
`define NFCD_CLK_NS 50
`define NFCD_CYCLE_CLKS (((`NFCD_CYCLE_NS + `NFCD_CLK_NS - 1) / `NFCD_CLK_NS) < 1 ? 1 : ((`NFCD_CYCLE_NS + `NFCD_CLK_NS - 1) / `NFCD_CLK_NS))
`define NFCD_BLOCK_SHIFT_BASE 5
`endif

//--- hdl/nfcd_pkg.sv
// Types shared by the flash controller front end.
package nfcd_pkg;
	typedef enum logic [1:0] {
		NFCD_OFF,
		NFCD_LOADING,
		NFCD_IDLE,
		NFCD_RUNNING
	} nfcd_state_t;
	typedef enum logic [1:0] {
		NFCD_OP_READ_ID,
		NFCD_OP_WRITE_BYTE,
		NFCD_OP_ERASE_BLOCK,
		NFCD_OP_NONE
	} nfcd_op_t;
endpackage

//--- hdl/nfcd_top.sv
// Configuration descriptor front end of the on-chip flash controller with a classic Wishbone slave.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`include "nfcd_cfg.svh"

module nfcd_top (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic ctrl_enable_bit_o,
	output logic running_flag_o,
	output logic config_done_o,
	output logic op_start_o,
	output logic [1:0] op_code_o,
	output logic [1:0] op_device_o,
	output logic op_reject_o
);
	localparam int CYCLE_CLKS = `NFCD_CYCLE_CLKS;

	// Bus side state.
	logic ack_reg, ack_next;
	logic [31:0] dat_reg, dat_next;
	logic en_reg, en_next;
	logic [2:0] ptr_reg, ptr_next;
	logic [7:0] desc_reg [0:7];
	logic [7:0] desc_next [0:7];
	nfcd_pkg::nfcd_state_t st_reg, st_next;
	logic [1:0] dev_reg, dev_next;
	nfcd_pkg::nfcd_op_t op_reg, op_next;
	logic start_reg, start_next;
	logic rej_reg, rej_next;
	logic [1:0] busy_cnt_reg, busy_cnt_next;
	logic [15:0] blk_reg, blk_next;

	// Request decode, one access per Wishbone request with a single-cycle answer.
	logic req;
	logic wr_lo;
	logic gclk_en;
	assign req = wb_cyc_i && wb_stb_i && !ack_reg;
	assign wr_lo = req && wb_we_i && wb_sel_i[0];
	assign gclk_en = en_reg; // Stands in for the gated controller clock.

	// Derived configuration fields.
	logic [1:0] dev_cnt_m1;
	logic card_en;
	logic [1:0] bsize;
	logic [15:0] first_blk, last_blk;
	logic [1:0] max_dev;
	logic dev_ok;
	logic in_prot;
	assign dev_cnt_m1 = desc_reg[`NFCD_IDX_SUB_ONE][6:5];
	assign card_en = desc_reg[`NFCD_IDX_SUB_ONE][0];
	assign bsize = desc_reg[`NFCD_IDX_SUB_TWO][1:0];
	assign first_blk = {desc_reg[`NFCD_IDX_FIRST_HIGH], desc_reg[`NFCD_IDX_FIRST_LOW]};
	assign last_blk = {desc_reg[`NFCD_IDX_LAST_HIGH], desc_reg[`NFCD_IDX_LAST_LOW]};
	assign max_dev = dev_cnt_m1;

	// Device legality: with card on, device three is the card and the flash devices count one less.
	always_comb begin
		if (card_en) begin
			dev_ok = (dev_reg == 2'h3) || (dev_reg < max_dev);
		end else begin
			dev_ok = (dev_reg <= max_dev);
		end
	end

	// Block address scaled by pages per block; the protected window guards the application segment.
	logic [15:0] blk_of_page;
	always_comb begin
		blk_of_page = blk_reg >> (`NFCD_BLOCK_SHIFT_BASE + 32'(bsize));
		in_prot = (blk_of_page >= first_blk) && (blk_of_page <= last_blk);
	end

	// Next-state logic for registers, descriptor pointer and the operation sequencer.
	always_comb begin
		ack_next = req;
		dat_next = 32'h0000_0000;
		en_next = en_reg;
		ptr_next = ptr_reg;
		st_next = st_reg;
		dev_next = dev_reg;
		op_next = op_reg;
		start_next = 1'b0;
		rej_next = 1'b0;
		busy_cnt_next = busy_cnt_reg;
		blk_next = blk_reg;
		for (int i = 0; i < `NFCD_DESC_BYTES; i++) begin
			desc_next[i] = desc_reg[i];
		end
		if (req && !wb_we_i) begin
			if (wb_adr_i == `NFCD_OFS_CONTROL) begin
				dat_next = {31'h0, en_reg};
			end else if (wb_adr_i == `NFCD_OFS_STATUS) begin
				dat_next = {24'h0, 1'b0, ptr_reg, st_reg == nfcd_pkg::NFCD_IDLE, rej_reg,
					st_reg == nfcd_pkg::NFCD_RUNNING, 1'b0};
			end else if (wb_adr_i == `NFCD_OFS_OPERATION) begin
				dat_next = {14'h0, blk_reg, 2'h0};
			end else begin
				dat_next = 32'h0000_0000;
			end
		end
		if (wr_lo && wb_adr_i == `NFCD_OFS_CONTROL) begin
			en_next = wb_dat_i[`NFCD_BIT_ENABLE];
		end
		if (!en_reg) begin
			ptr_next = 3'h0;
			st_next = nfcd_pkg::NFCD_OFF;
			if (en_next) begin
				st_next = nfcd_pkg::NFCD_LOADING;
			end
		end else begin
			case (st_reg)
				nfcd_pkg::NFCD_RUNNING: begin
					if (busy_cnt_reg == 2'h0) begin
						st_next = nfcd_pkg::NFCD_IDLE;
					end else begin
						busy_cnt_next = busy_cnt_reg - 2'h1;
					end
				end
				nfcd_pkg::NFCD_IDLE: begin
					if (wr_lo && wb_adr_i == `NFCD_OFS_OPERATION && gclk_en) begin
						dev_next = wb_dat_i[3:2];
						op_next = nfcd_pkg::nfcd_op_t'(wb_dat_i[1:0]);
						blk_next = wb_dat_i[19:4];
					end
				end
				default: ;
			endcase
			if (wr_lo && wb_adr_i == `NFCD_OFS_DESCRIPTOR && gclk_en && st_reg != nfcd_pkg::NFCD_RUNNING) begin
				// Each write stores the next byte with reserved bits forced to zero.
				case (ptr_reg)
					`NFCD_IDX_NAND_PAGE, `NFCD_IDX_CARD_PAGE: desc_next[ptr_reg] = wb_dat_i[7:0] & `NFCD_PAGE_MASK;
					`NFCD_IDX_SUB_ONE: desc_next[ptr_reg] = wb_dat_i[7:0] & `NFCD_SUB_ONE_MASK;
					`NFCD_IDX_SUB_TWO: desc_next[ptr_reg] = wb_dat_i[7:0] & `NFCD_SUB_TWO_MASK;
					default: desc_next[ptr_reg] = wb_dat_i[7:0];
				endcase
				ptr_next = ptr_reg + 3'h1; // Wraps to zero after byte seven.
				st_next = nfcd_pkg::NFCD_LOADING;
				if (ptr_reg == `NFCD_IDX_LAST_LOW) begin
					st_next = nfcd_pkg::NFCD_IDLE;
				end
			end
		end
	end

	// Operation launch is a separate pass so the sequencer sees the latched request.
	logic launch;
	always_comb begin
		launch = en_reg && st_reg == nfcd_pkg::NFCD_IDLE && ack_reg && wb_we_i && wb_adr_i == `NFCD_OFS_OPERATION
			&& op_reg != nfcd_pkg::NFCD_OP_NONE;
	end

	// Registers; launched operations override the next state computed above.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
			en_reg <= 1'b0;
			ptr_reg <= 3'h0;
			st_reg <= nfcd_pkg::NFCD_OFF;
			dev_reg <= 2'h0;
			op_reg <= nfcd_pkg::NFCD_OP_NONE;
			start_reg <= 1'b0;
			rej_reg <= 1'b0;
			busy_cnt_reg <= 2'h0;
			blk_reg <= 16'h0000;
			desc_reg[0] <= `NFCD_RST_PAGE;
			desc_reg[1] <= `NFCD_RST_PAGE;
			desc_reg[2] <= `NFCD_RST_SUB_ONE;
			desc_reg[3] <= `NFCD_RST_SUB_TWO;
			for (int i = 4; i < `NFCD_DESC_BYTES; i++) begin
				desc_reg[i] <= `NFCD_RST_PROT;
			end
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
			en_reg <= en_next;
			ptr_reg <= ptr_next;
			dev_reg <= dev_next;
			op_reg <= op_next; // The code stays latched so the devices see it while the start pulse stands.
			blk_reg <= blk_next;
			for (int i = 0; i < `NFCD_DESC_BYTES; i++) begin
				desc_reg[i] <= desc_next[i];
			end
			if (launch && (!dev_ok || (op_reg != nfcd_pkg::NFCD_OP_READ_ID && in_prot))) begin
				st_reg <= st_next;
				start_reg <= 1'b0;
				rej_reg <= 1'b1;
				busy_cnt_reg <= busy_cnt_next;
			end else if (launch) begin
				st_reg <= nfcd_pkg::NFCD_RUNNING;
				start_reg <= 1'b1;
				rej_reg <= 1'b0;
				busy_cnt_reg <= 2'(CYCLE_CLKS - 1);
			end else begin
				st_reg <= st_next;
				start_reg <= start_next;
				rej_reg <= rej_reg && !(wr_lo && wb_adr_i == `NFCD_OFS_STATUS) ? 1'b1 : rej_next;
				busy_cnt_reg <= busy_cnt_next;
			end
		end
	end

	// Outputs from flip-flops; the running and idle flags are decoded from the state register.
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
	assign ctrl_enable_bit_o = en_reg;
	assign running_flag_o = (st_reg == nfcd_pkg::NFCD_RUNNING);
	assign config_done_o = (st_reg == nfcd_pkg::NFCD_IDLE);
	assign op_start_o = start_reg;
	assign op_code_o = op_reg;
	assign op_device_o = dev_reg;
	assign op_reject_o = rej_reg;

	// Checks beside the logic.
	a_ptr_clear_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i) !en_reg |=> ptr_reg == 3'h0)
		else $error("descriptor pointer not cleared while disabled");
	a_ptr_advance: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(wr_lo && wb_adr_i == `NFCD_OFS_DESCRIPTOR && en_reg && en_next && st_reg != nfcd_pkg::NFCD_RUNNING)
		|=> ptr_reg == $past(ptr_reg) + 3'h1)
		else $error("descriptor pointer did not advance");
	a_no_write_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i) !en_reg |=> $stable(desc_reg[0]))
		else $error("descriptor changed without clock");
	a_idle_after_last: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(wr_lo && wb_adr_i == `NFCD_OFS_DESCRIPTOR && en_reg && en_next && ptr_reg == 3'h7 && st_reg != nfcd_pkg::NFCD_RUNNING)
		|=> config_done_o && !running_flag_o)
		else $error("not idle after full descriptor");
	a_page_low_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i) desc_reg[0][2:0] == 3'h0)
		else $error("page reserved bits set");
	a_ack_one: assert property (@(posedge mclk_i) disable iff (!rst_b_i) wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	a_run_end: assert property (@(posedge mclk_i) disable iff (!rst_b_i) $rose(running_flag_o) |-> ##[1:4] !running_flag_o)
		else $error("operation never completed");
	a_start_idle: assert property (@(posedge mclk_i) disable iff (!rst_b_i) op_start_o |-> running_flag_o && $past(config_done_o))
		else $error("operation started without descriptor");

	// Further checks on the bus answer, the descriptor fields and the launch conditions.
	// Each one watches state that the tests reach only through the register port.

	// Every accepted request is answered in the next cycle.
	// A missing answer would stall the master until its own timeout.
	a_ack_after_req: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		req |=> wb_ack_o)
		else $error("request not answered");

	// A read of the control register returns the enable bit in bit zero.
	// Software uses it to learn whether the controller is clocked.
	a_ctrl_read: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(req && !wb_we_i && wb_adr_i == `NFCD_OFS_CONTROL) |=> wb_dat_o == {31'h0, $past(en_reg)})
		else $error("control read wrong");

	// Reads of unmapped offsets, the descriptor port included, return zero.
	// Descriptor bytes are write only, so nothing of them may leak out here.
	a_unmapped_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(req && !wb_we_i && wb_adr_i != `NFCD_OFS_CONTROL && wb_adr_i != `NFCD_OFS_STATUS
		&& wb_adr_i != `NFCD_OFS_OPERATION) |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	// The reserved top bit of the first sub setup byte stays clear.
	// A set bit would shift the device count read by the launch check.
	a_sub_one_top: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		desc_reg[`NFCD_IDX_SUB_ONE][7] == 1'b0)
		else $error("sub setup one reserved bit set");

	// Only the two block size bits of the second sub setup byte can be set.
	// Wider values would scale the protected window by a wrong shift.
	a_sub_two_top: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		desc_reg[`NFCD_IDX_SUB_TWO][7:2] == 6'h00)
		else $error("sub setup two reserved bits set");

	// The card page byte shares the layout of the flash page byte.
	// Its low three bits therefore read as zero as well.
	a_card_page_low: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		desc_reg[`NFCD_IDX_CARD_PAGE][2:0] == 3'h0)
		else $error("card page reserved bits set");

	// Turning the controller on always starts a descriptor at byte zero.
	// A stale pointer would put the first byte into the wrong field.
	a_first_byte_zero: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$rose(en_reg) |-> ptr_reg == 3'h0)
		else $error("pointer not zero after enable");

	// Writing the last byte wraps the pointer, so a fresh descriptor can follow.
	// Without the wrap a second descriptor would be refused or misplaced.
	a_wrap_last: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(wr_lo && wb_adr_i == `NFCD_OFS_DESCRIPTOR && en_reg && ptr_reg == 3'h7
		&& st_reg != nfcd_pkg::NFCD_RUNNING) |=> ptr_reg == 3'h0)
		else $error("pointer did not wrap");

	// Without its clock the controller neither runs nor reports idle.
	// Software must see that a disabled controller takes no requests.
	a_off_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!en_reg |=> !running_flag_o && !config_done_o)
		else $error("controller active while disabled");

	// The last protected byte cannot change while the clock is off.
	// This guards the other end of the descriptor from the first check.
	a_last_stable_off: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		!en_reg |=> $stable(desc_reg[`NFCD_IDX_LAST_LOW]))
		else $error("protected block changed without clock");

	// Running only ever begins with a start pulse from a software request.
	// The controller must never start a sequence on its own.
	a_run_by_start: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$rose(running_flag_o) |-> op_start_o)
		else $error("running without request");

	// A started operation carries a real code, never the empty one.
	// The devices would otherwise be strobed with nothing to do.
	a_start_code: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		op_start_o |-> op_code_o != 2'h3)
		else $error("start with empty code");

	// A started operation addresses a device that the descriptor allows.
	// With card support the card is device three and the others count one less.
	a_start_device: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		op_start_o |-> (card_en ? (op_device_o == 2'h3 || op_device_o < dev_cnt_m1) : op_device_o <= dev_cnt_m1))
		else $error("start on illegal device");

	// A write or erase never starts inside the protected block range.
	// Identifier reads are harmless and are let through anywhere.
	a_start_unprotected: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		(op_start_o && op_code_o != 2'h0) |-> !in_prot)
		else $error("start inside protected range");

	// A refused request never pulses start in the same cycle.
	// Reject and launch are exclusive outcomes of one request.
	a_reject_quiet: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		op_reject_o |-> !op_start_o)
		else $error("start and reject together");
endmodule // nfcd_top

//--- test/nfcd_flash_model.sv
// Stand-in for the attached flash devices.
`timescale 1ns/1ps
module nfcd_flash_model (
	input wire logic mclk_i,
	input wire logic op_start_i,
	input wire logic [1:0] op_code_i,
	input wire logic [1:0] op_device_i,
	output int starts_o,
	output logic [1:0] last_code_o,
	output logic [1:0] last_device_o
);
	initial starts_o = 0;
	// Each launch is counted, and its code and device number are kept.
	always @(posedge mclk_i) begin
		if (op_start_i === 1'b1) begin
			starts_o <= starts_o + 1;
			last_code_o <= op_code_i;
			last_device_o <= op_device_i;
		end
	end
endmodule // nfcd_flash_model

//--- test/test_nfcd_top.sv
// Bench of the flash controller front end.
`timescale 1ns/1ps
`include "nfcd_cfg.svh"
module test_nfcd_top;
	typedef struct {logic [1:0] op; logic [1:0] dev; logic [15:0] pg; logic rj;} nfcd_row_t;
	logic mclk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] rdat, q;
	logic ack, en, run, done, start, rej;
	logic [1:0] code, dev, last_code, last_dev;
	int err_count = 0;
	int tests_run = 0;
	int starts;
	nfcd_row_t rows [7] = '{'{2'h0, 2'h0, 16'h0064, 1'b0}, '{2'h1, 2'h1, 16'h000A, 1'b0},
		'{2'h2, 2'h1, 16'h0040, 1'b1}, '{2'h1, 2'h0, 16'h007F, 1'b1}, '{2'h1, 2'h0, 16'h0080, 1'b0},
		'{2'h2, 2'h2, 16'h0000, 1'b1}, '{2'h0, 2'h1, 16'h0000, 1'b0}};
	nfcd_top i_nfcd_top (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ctrl_enable_bit_o(en), .running_flag_o(run), .config_done_o(done), .op_start_o(start),
		.op_code_o(code), .op_device_o(dev), .op_reject_o(rej));
	nfcd_flash_model i_nfcd_flash_model (.mclk_i(mclk_i), .op_start_i(start), .op_code_i(code),
		.op_device_i(dev), .starts_o(starts), .last_code_o(last_code), .last_device_o(last_dev));
	// Clock of 50 ns.
	initial forever #25 mclk_i = ~mclk_i;
	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Compares a seen value with the expected one.
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One classic Wishbone cycle; read data lands in q.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			err_count++;
			complete_run();
		end
	endtask
	// Loads a descriptor with protected blocks 2 to 3, checking the byte pointer.
	task automatic load(input logic [7:0] sub2, input logic [7:0] sub1);
		logic [63:0] d;
		d = {8'h03, 8'h00, 8'h02, 8'h00, sub2, sub1, 8'h08, 8'h08};
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, `NFCD_OFS_DESCRIPTOR, {24'h0, d[8*i +: 8]});
			bus(1'b0, `NFCD_OFS_STATUS, 32'h0);
			chk("pointer", {29'h0, q[6:4]}, 32'((i + 1) % 8));
		end
		chk("idle", {31'h0, done}, 32'h1);
		chk("idle bit", {31'h0, q[3]}, 32'h1);
	endtask
	// Requests one operation and checks launch or refusal.
	task automatic op_req(input logic [1:0] o, input logic [1:0] dv, input logic [15:0] pg, input logic rj);
		int s0;
		s0 = starts;
		bus(1'b1, `NFCD_OFS_OPERATION, {12'h0, pg, dv, o});
		@(posedge mclk_i);
		chk("running", {31'h0, run}, {31'h0, ~rj});
		repeat (3) @(posedge mclk_i);
		chk("launches", starts - s0, {31'h0, ~rj});
		chk("reject", {31'h0, rej}, {31'h0, rj});
		if (!rj) begin
			chk("op code", {30'h0, last_code}, {30'h0, o});
			chk("device", {30'h0, last_dev}, {30'h0, dv});
		end
	endtask
	// Main sequence.
	initial begin
		repeat (3) @(posedge mclk_i);
		chk("enable", {31'h0, en}, 32'h0);
		chk("reset code", {30'h0, code}, 32'h3);
		rst_b_i <= 1'b1;
		bus(1'b1, `NFCD_OFS_DESCRIPTOR, 32'h55);
		bus(1'b0, `NFCD_OFS_STATUS, 32'h0);
		chk("status", q, 32'h0);
		$display("test reset done");
		bus(1'b1, `NFCD_OFS_CONTROL, 32'h1);
		chk("enable on", {31'h0, en}, 32'h1);
		load(8'h00, 8'h20);
		foreach (rows[i])
			op_req(rows[i].op, rows[i].dev, rows[i].pg, rows[i].rj);
		$display("test table done");
		for (int c = 0; c < 4; c++) begin
			load(8'(c), 8'h20);
			op_req(2'h1, 2'h0, (16'h0040 << c) - 16'h0001, 1'b0);
			op_req(2'h2, 2'h1, 16'h0040 << c, 1'b1);
			op_req(2'h1, 2'h1, (16'h0080 << c) - 16'h0001, 1'b1);
			op_req(2'h1, 2'h1, 16'h0080 << c, 1'b0);
		end
		$display("test block size done");
		load(8'h00, 8'h01);
		op_req(2'h0, 2'h3, 16'h0000, 1'b0);
		op_req(2'h0, 2'h0, 16'h0000, 1'b1);
		$display("test card done");
		for (int i = 0; i < 3; i++)
			bus(1'b1, `NFCD_OFS_DESCRIPTOR, 32'hFF);
		bus(1'b1, `NFCD_OFS_CONTROL, 32'h0);
		chk("enable off", {31'h0, en}, 32'h0);
		bus(1'b1, `NFCD_OFS_CONTROL, 32'h1);
		bus(1'b0, `NFCD_OFS_STATUS, 32'h0);
		chk("pointer", {29'h0, q[6:4]}, 32'h0);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("test abort done");
		complete_run();
	end
endmodule // test_nfcd_top
